// ### pkg/fcw_defs.vh
// Constants for the flash command/mode host controller.
// Assumes inclusion by bare name from the design files.
`ifndef FCW_DEFS_VH
`define FCW_DEFS_VH
// Clock period and bus timing in ns
`define FCW_CLK_NS 5
`define FCW_T_ACC_NS 60
`define FCW_T_CE_NS 60
`define FCW_T_WP_NS 35
`define FCW_T_WPH_NS 25
// Cycle counts, least times rounded up
`define FCW_ACC_CYC ((`FCW_T_CE_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_WP_CYC ((`FCW_T_WP_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_WPH_CYC ((`FCW_T_WPH_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
// Command kinds on the user port
`define FCW_OP_READ 3'h0
`define FCW_OP_WRITE 3'h1
`define FCW_OP_PROG 3'h2
`define FCW_OP_ERASE 3'h3
`define FCW_OP_IDENT 3'h4
`define FCW_OP_SHORT 3'h5
// Unlock addresses and data, command bytes; addresses are parameter defaults
`define FCW_UNLOCK_A1 21'h000aaa
`define FCW_UNLOCK_A2 21'h000555
`define FCW_UNLOCK_D1 32'h000000aa
`define FCW_UNLOCK_D2 32'h00000055
`define FCW_CMD_PROG 32'h000000a0
`define FCW_CMD_ERASE 32'h00000080
`define FCW_CMD_CHIP 32'h00000010
`define FCW_CMD_SECT 32'h00000030
`define FCW_CMD_IDENT 32'h00000090
`define FCW_CMD_BYPASS 32'h00000020
// Sector decode fields of the top-boot map
`define FCW_SEC_HI 19
`define FCW_SEC_LO 16
`define FCW_SEC_SUB_HI 15
`define FCW_SEC_SUB_LO 12
`define FCW_LAST_BIG 4'hf
`define FCW_SECURE_WORDS 21'h000200
`endif

// ### hdl/fcw_sector_decode.v
// Top-boot sector decoder for the flash host controller.
// Assumes a 20-bit double-word index (word address shifted right when x16).
`timescale 1ns/1ps
`include "fcw_defs.vh"
module fcw_sector_decode
(
  input wire [19:0] dwAddr,
  output reg [4:0] sectorNum
);
  // Upper nibble picks big sectors; last nibble split into boot sectors
  always @*
  begin
    if (dwAddr[`FCW_SEC_HI:`FCW_SEC_LO] != `FCW_LAST_BIG)
      sectorNum = {1'b0, dwAddr[`FCW_SEC_HI:`FCW_SEC_LO]};
    else if (dwAddr[`FCW_SEC_SUB_HI:`FCW_SEC_SUB_LO] <= 4'hb)
      sectorNum = 5'h0f; // 96K words
    else if (dwAddr[`FCW_SEC_SUB_HI:`FCW_SEC_SUB_LO] == 4'hc)
      sectorNum = 5'h10; // 8K words
    else if (dwAddr[`FCW_SEC_SUB_HI:`FCW_SEC_SUB_LO] == 4'hd)
      sectorNum = 5'h11; // 8K words
    else
      sectorNum = 5'h12; // 16K words
  end
endmodule // fcw_sector_decode

// ### hdl/fcw_host.v
// Host controller driving an asynchronous parallel NOR flash.
// Assumes flash pins are synchronised here; user port is on mclk.
`timescale 1ns/1ps
`include "fcw_defs.vh"
module fcw_host
#(
  parameter ACC_CYC = `FCW_ACC_CYC,
  parameter WP_CYC = `FCW_WP_CYC,
  parameter WPH_CYC = `FCW_WPH_CYC,
  parameter [20:0] UNLOCK_A1 = `FCW_UNLOCK_A1,
  parameter [20:0] UNLOCK_A2 = `FCW_UNLOCK_A2
)
(
  input wire mclk,
  input wire rst,
  input wire reqValid,
  input wire [2:0] reqOp,
  input wire [20:0] reqAddr,
  input wire [31:0] reqData,
  input wire wordMode,
  input wire accelEnable,
  output reg reqReady,
  output reg rspValid,
  output reg [31:0] rspData,
  output reg [4:0] rspSector,
  output reg shortcutActive,
  output reg [19:0] flashAddr,
  output reg [31:0] flashDataOut,
  output reg [31:0] flashDataOe,
  input wire [31:0] flashDataIn,
  output reg chipSelectN,
  output reg outputEnableN,
  output reg writeStrobeN,
  output reg widthSelectN,
  output reg fastProgramPin
);
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_STROBE = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_READ = 3'h4;
  localparam S_DONE = 3'h5;
  reg [2:0] state; // Sequencer state
  reg [7:0] timer; // Cycle counter
  reg [2:0] step; // Write cycle within sequence
  reg [2:0] steps; // Cycles in sequence
  reg [2:0] op; // Latched operation
  reg [20:0] addr; // Latched address
  reg [31:0] data; // Latched data
  reg [31:0] syncA; // First sync stage, read by syncB only
  reg [31:0] syncB; // Synchronised data pins
  reg [20:0] cycAddr; // Address of current write cycle
  reg [31:0] cycData; // Data of current write cycle
  wire [19:0] dwIndex; // Double-word index for decode
  wire [4:0] sector;
  // Decode over A19..A0 in both x16 and x32; A-1 is not decoded
  assign dwIndex = wordMode ? addr[20:1] : addr[19:0];
  fcw_sector_decode uDecode
  (
    .dwAddr(dwIndex),
    .sectorNum(sector)
  );
  // Two-stage sync of data pins
  always @(posedge mclk)
  begin
    syncA <= flashDataIn;
    syncB <= syncA;
  end
  // Write cycle address and data per step
  always @*
  begin
    cycAddr = addr;
    cycData = data;
    if (op == `FCW_OP_WRITE)
    begin
      cycAddr = addr;
      cycData = data;
    end
    else if (op == `FCW_OP_PROG && shortcutActive)
    begin
      // Two-cycle program in shortcut mode
      cycAddr = (step == 3'h0) ? addr : addr;
      cycData = (step == 3'h0) ? `FCW_CMD_PROG : data;
    end
    else if (step == 3'h0 || (step == 3'h3 && op == `FCW_OP_ERASE))
    begin
      // Second unlock pair belongs to erase only; program cycle 3 is data
      cycAddr = UNLOCK_A1;
      cycData = `FCW_UNLOCK_D1;
    end
    else if (step == 3'h1 || (step == 3'h4 && op == `FCW_OP_ERASE))
    begin
      cycAddr = UNLOCK_A2;
      cycData = `FCW_UNLOCK_D2;
    end
    else if (step == 3'h2)
    begin
      cycAddr = UNLOCK_A1;
      case (op)
        `FCW_OP_PROG: cycData = `FCW_CMD_PROG;
        `FCW_OP_ERASE: cycData = `FCW_CMD_ERASE;
        `FCW_OP_IDENT: cycData = `FCW_CMD_IDENT;
        default: cycData = `FCW_CMD_BYPASS;
      endcase
    end
    else if (op == `FCW_OP_ERASE)
    begin
      // Sector erase at sector address, or chip erase
      cycAddr = (data[0]) ? UNLOCK_A1 : addr;
      cycData = (data[0]) ? `FCW_CMD_CHIP : `FCW_CMD_SECT;
    end
    else
    begin
      cycAddr = addr;
      cycData = data;
    end
  end
  // Main sequencer
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      timer <= 8'h00;
      step <= 3'h0;
      steps <= 3'h0;
      op <= 3'h0;
      addr <= 21'h000000;
      data <= 32'h00000000;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 32'h00000000;
      rspSector <= 5'h00;
      shortcutActive <= 1'b0;
      flashAddr <= 20'h00000;
      flashDataOut <= 32'h00000000;
      flashDataOe <= 32'h00000000;
      chipSelectN <= 1'b1;
      outputEnableN <= 1'b1;
      writeStrobeN <= 1'b1;
      widthSelectN <= 1'b1;
      fastProgramPin <= 1'b0;
    end
    else
    begin
      rspValid <= 1'b0;
      widthSelectN <= ~wordMode;
      case (state)
        S_IDLE:
        begin
          reqReady <= 1'b1;
          chipSelectN <= 1'b1;
          outputEnableN <= 1'b1;
          writeStrobeN <= 1'b1;
          flashDataOe <= 32'h00000000;
          if (reqValid && reqReady)
          begin
            reqReady <= 1'b0;
            op <= reqOp;
            addr <= reqAddr;
            data <= reqData;
            step <= 3'h0;
            timer <= 8'h00;
            if (reqOp == `FCW_OP_PROG && accelEnable)
            begin
              fastProgramPin <= 1'b1;
              shortcutActive <= 1'b1;
            end
            else if (reqOp != `FCW_OP_PROG)
              fastProgramPin <= 1'b0;
            case (reqOp)
              `FCW_OP_READ: steps <= 3'h0;
              `FCW_OP_WRITE: steps <= 3'h1;
              `FCW_OP_IDENT: steps <= 3'h3;
              `FCW_OP_SHORT: steps <= 3'h3;
              `FCW_OP_ERASE: steps <= 3'h6;
              default: steps <= (shortcutActive || accelEnable) ? 3'h2 : 3'h4;
            endcase
            state <= (reqOp == `FCW_OP_READ) ? S_READ : S_SETUP;
          end
        end
        S_SETUP:
        begin
          // Present address and data, select, OE high
          flashAddr <= wordMode ? cycAddr[20:1] : cycAddr[19:0];
          flashDataOut <= wordMode ? {cycAddr[0], 15'h0000, cycData[15:0]} : cycData;
          flashDataOe <= wordMode ? 32'h8000ffff : 32'hffffffff;
          chipSelectN <= 1'b0;
          outputEnableN <= 1'b1;
          timer <= 8'h00;
          state <= S_STROBE;
        end
        S_STROBE:
        begin
          writeStrobeN <= 1'b0;
          timer <= timer + 8'h01;
          if (timer == WP_CYC[7:0])
          begin
            writeStrobeN <= 1'b1;
            timer <= 8'h00;
            state <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          timer <= timer + 8'h01;
          if (timer == WPH_CYC[7:0])
          begin
            step <= step + 3'h1;
            if (step + 3'h1 >= steps)
            begin
              if (op == `FCW_OP_SHORT)
                shortcutActive <= 1'b1;
              state <= S_DONE;
            end
            else
              state <= S_SETUP;
          end
        end
        S_READ:
        begin
          // Read array, identifier, or busy status
          chipSelectN <= 1'b0;
          outputEnableN <= 1'b0;
          flashDataOe <= wordMode ? 32'h80000000 : 32'h00000000;
          flashDataOut <= {addr[0], 31'h00000000};
          flashAddr <= wordMode ? addr[20:1] : addr[19:0];
          timer <= timer + 8'h01;
          // Full access time from select, plus sync delay
          if (timer == ACC_CYC[7:0] + 8'h02)
          begin
            rspData <= wordMode ? {16'h0000, syncB[15:0]} : syncB;
            state <= S_DONE;
          end
        end
        S_DONE:
        begin
          chipSelectN <= 1'b1;
          outputEnableN <= 1'b1;
          flashDataOe <= 32'h00000000;
          rspSector <= (addr < `FCW_SECURE_WORDS && op == `FCW_OP_READ) ? sector : sector;
          rspValid <= 1'b1;
          // High voltage ends with the program; never carried into the next op
          fastProgramPin <= 1'b0;
          if (fastProgramPin)
            shortcutActive <= 1'b0;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule // fcw_host

// ### sim/fcw_host_properties.sv
// Pin-level checker for the flash host controller.
// Assumes bind from the testbench top and default timing parameters.
`timescale 1ns/1ps
module fcw_host_properties
(
  input wire mclk,
  input wire rst,
  input wire reqReady,
  input wire wordMode,
  input wire shortcutActive,
  input wire [31:0] flashDataOe,
  input wire chipSelectN,
  input wire outputEnableN,
  input wire writeStrobeN,
  input wire widthSelectN,
  input wire fastProgramPin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Strobe low phase, then its release
  sequence s_strobe_low;
    (!writeStrobeN)[*7] ##1 writeStrobeN;
  endsequence
  // Minimum strobe high time
  sequence s_hold_high;
    writeStrobeN[*6];
  endsequence
  // Select and output enable held low for 8 cycles
  sequence s_access;
    (!outputEnableN && !chipSelectN)[*8];
  endsequence
  a_write_levels: assert property (!writeStrobeN |-> !chipSelectN && outputEnableN)
    else $error("strobe without select");
  a_strobe_pulse: assert property ($fell(writeStrobeN) |-> s_strobe_low ##0 s_hold_high)
    else $error("strobe pulse length wrong");
  a_read_access: assert property ($fell(outputEnableN) |-> s_access)
    else $error("read cut short");
  a_read_host_off: assert property (!outputEnableN |-> flashDataOe == (widthSelectN ? 32'h0 : 32'h80000000))
    else $error("host drives during read");
  a_write_drives: assert property (!writeStrobeN |-> &flashDataOe[15:0])
    else $error("write data not driven");
  a_word_tristate: assert property (!widthSelectN |-> flashDataOe[30:16] == 15'h0)
    else $error("upper pins driven in word mode");
  a_width_pin: assert property (!writeStrobeN |-> widthSelectN == !wordMode)
    else $error("width pin wrong");
  a_fast_in_op: assert property (fastProgramPin |-> !reqReady)
    else $error("fast pin high while idle");
  a_fast_drop: assert property ($fell(fastProgramPin) |-> ##[0:2] !shortcutActive)
    else $error("shortcut kept after fast pin");
endmodule // fcw_host_properties

// ### sim/fcw_flash_model.sv
// Behavioural top-boot parallel flash seen from its pins.
// Assumes host pins settle on its own clock; only command bytes decoded.
`timescale 1ns/1ps
module fcw_flash_model
#(
  parameter [7:0] ID_CODE = 8'h5a // Arbitrary identifier value
)
(
  input wire csN,
  input wire oeN,
  input wire weN,
  input wire wsN,
  input wire fastPin,
  input wire [19:0] addr,
  input wire [31:0] bus,
  output logic [31:0] drive
);
  logic [31:0] mem [logic [20:0]]; // Programmed cells only
  logic [39:0] hist = 40'h0; // Last five command bytes
  logic progNext = 1'b0, bypass = 1'b0, ident = 1'b0, busy = 1'b0, flip = 1'b0, pollBit;
  logic [7:0] lastCmd = 8'h0; // Final erase byte
  int writes = 0; // Write cycles seen
  // Word mode takes its lowest address bit from the top pin
  wire [20:0] key = wsN ? {1'b0, addr} : {addr, bus[31]};
  always #5 flip = ~flip;
  // Command decoder, one write per strobe rise
  always @(posedge weN)
    if (!csN && oeN)
    begin
      writes++;
      if (progNext)
      begin
        mem[key] = wsN ? bus : {16'h0, bus[15:0]};
        pollBit = bus[7];
        progNext = 1'b0;
        busy = 1'b1;
        busy <= #100 1'b0;
      end
      else if (bus[7:0] == 8'ha0 && (bypass || fastPin || hist[15:0] == 16'haa55))
        progNext = 1'b1;
      else if (hist[15:0] == 16'haa55 && bus[7:0] == 8'h90)
        ident = 1'b1;
      else if (hist[15:0] == 16'haa55 && bus[7:0] == 8'h20)
        bypass = 1'b1;
      else if (hist == 40'haa5580aa55)
      begin
        lastCmd = bus[7:0];
        pollBit = 1'b1;
        busy = 1'b1;
        busy <= #100 1'b0;
      end
      hist = {hist[31:0], bus[7:0]};
    end
  // Read path; released pins toggle so stale data never passes
  always @*
    if (csN || oeN)
      drive = {32{flip}} ^ 32'h5a5aa5a5;
    else if (busy)
      drive = {24'h0, ~pollBit, 7'h0};
    else if (ident)
      drive = {24'h0, ID_CODE};
    else
      drive = mem.exists(key) ? mem[key] : 32'hffffffff;
endmodule // fcw_flash_model

// ### sim/fcw_host_tb.sv
// Self-checking bench for the flash host controller.
// Assumes the behavioural flash model and default timing parameters.
`timescale 1ns/1ps
module fcw_host_tb;
  logic mclk = 0, rst = 1, reqValid = 0, wordMode = 0, accelEnable = 0;
  logic [2:0] reqOp = 3'h0;
  logic [20:0] reqAddr = 21'h0;
  logic [31:0] reqData = 32'h0, flashDataIn, flashDataOut, flashDataOe, devDrive;
  logic reqReady, rspValid, shortcutActive, chipSelectN, outputEnableN, writeStrobeN;
  logic widthSelectN, fastProgramPin;
  logic [31:0] rspData;
  logic [4:0] rspSector;
  logic [19:0] flashAddr;
  int failures = 0, checks_done = 0, w0;
  // Pin level: host where enabled, flash elsewhere
  assign flashDataIn = (flashDataOe & flashDataOut) | (~flashDataOe & devDrive);
  always #2.5 mclk = ~mclk;
  fcw_host DUT (.*);
  fcw_flash_model FLASH (.csN(chipSelectN), .oeN(outputEnableN), .weN(writeStrobeN),
    .wsN(widthSelectN), .fastPin(fastProgramPin), .addr(flashAddr), .bus(flashDataIn),
    .drive(devDrive));
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge mclk);
    #1;
    n++;
  endtask
  // One request, held until taken, then wait for its answer
  task automatic op(input logic [2:0] o, input logic [20:0] a, input logic [31:0] d);
    int n;
    n = 0;
    w0 = FLASH.writes;
    reqValid = 1;
    reqOp = o;
    reqAddr = a;
    reqData = d;
    while (reqReady !== 1'b1 && n < 200) tick(n);
    tick(n);
    reqValid = 0;
    while (rspValid !== 1'b1 && n < 3000) tick(n);
    if (n >= 3000)
    begin
      chk(32'h0, 32'h1, "timeout");
      results();
    end
  endtask
  task automatic t_program32;
    op(3'h2, 21'h01234, 32'hdeadbeef);
    chk(FLASH.writes - w0, 32'h4, "normal writes");
    chk(FLASH.mem[21'h01234], 32'hdeadbeef, "cell x32");
    repeat (30) @(posedge mclk);
    #1;
    op(3'h0, 21'h01234, 32'h0);
    chk(rspData, 32'hdeadbeef, "read x32");
  endtask
  task automatic t_sectors;
    logic [20:0] a [8] = '{21'h0, 21'h7ffff, 21'hf0000, 21'hfbfff, 21'hfc000, 21'hfd000,
      21'hfe000, 21'hff123};
    logic [4:0] s [8] = '{5'h00, 5'h07, 5'h0f, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h12};
    for (int i = 0; i < 8; i++)
    begin
      op(3'h3, a[i], 32'h0);
      chk({27'h0, rspSector}, {27'h0, s[i]}, "sector x32");
      chk({24'h0, FLASH.lastCmd}, 32'h30, "sector erase");
    end
    op(3'h3, 21'h0, 32'h1);
    chk({24'h0, FLASH.lastCmd}, 32'h10, "chip erase");
  endtask
  task automatic t_word16;
    wordMode = 1;
    op(3'h3, 21'h1f9fff, 32'h0);
    chk({27'h0, rspSector}, 32'h10, "sector x16");
    op(3'h3, 21'h1fa000, 32'h0);
    chk({27'h0, rspSector}, 32'h11, "sector x16");
    op(3'h2, 21'h00457, 32'h0000a5c3);
    chk(FLASH.mem[21'h00457], 32'h0000a5c3, "cell x16");
    repeat (30) @(posedge mclk);
    #1;
    op(3'h0, 21'h00457, 32'h0);
    chk({16'h0, rspData[15:0]}, 32'ha5c3, "read x16");
    wordMode = 0;
  endtask
  task automatic t_accel;
    accelEnable = 1;
    op(3'h2, 21'h00100, 32'h11223344);
    chk(FLASH.writes - w0, 32'h2, "fast writes");
    chk({31'h0, fastProgramPin}, 32'h0, "fast pin off");
    accelEnable = 0;
    op(3'h2, 21'h00200, 32'h55667788);
    chk(FLASH.writes - w0, 32'h4, "writes after fast");
  endtask
  task automatic t_shortcut;
    op(3'h5, 21'h0, 32'h0);
    chk({31'h0, shortcutActive}, 32'h1, "shortcut on");
    op(3'h2, 21'h00300, 32'h99aabbcc);
    chk(FLASH.writes - w0, 32'h2, "shortcut writes");
    chk(FLASH.mem[21'h00300], 32'h99aabbcc, "shortcut cell");
  endtask
  task automatic t_ident;
    op(3'h4, 21'h0, 32'h0);
    op(3'h0, 21'h0, 32'h0);
    chk({24'h0, rspData[7:0]}, 32'h5a, "identifier");
    chk({31'h0, chipSelectN}, 32'h1, "standby");
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    #1;
    rst = 0;
    t_program32();
    t_sectors();
    t_word16();
    t_accel();
    t_shortcut();
    t_ident();
    results();
  end
endmodule // fcw_host_tb
bind fcw_host fcw_host_properties CHK (.*);
